// File: board_reset_and_init_control_test.sv
// Self-checking bench for the board reset controller with a host model.
// Assumes a 100 MHz clock; hold time shortened to a few cycles.
`timescale 1ns/1ps
module board_reset_and_init_control_test;
    import brc_pkg::*;
    localparam int unsigned HOLD  = 16;
    localparam int unsigned NCH   = 4;
    localparam int          LIMIT = 5000;
    localparam logic [7:0]  LINE_IRQ  = 8'h01;
    localparam logic [7:0]  CHCTL_IRQ = 8'h08;
    localparam logic [5:0]  CH_REGS [9] = '{DMA_STAT, DMA_ERR, DMA_DEV, DMA_OPER,
        DMA_SEQ, DMA_CHCTL, DMA_NVEC, DMA_EVEC, DMA_PRIO};
    localparam logic [7:0]  AUX_OP [5] = '{AUX_SEND_EOI, AUX_SET_REQSYS,
        AUX_SET_PPF, AUX_CLR_REQSYS, AUX_CLR_PPF};
    localparam logic [7:0]  AUX_ST [5] = '{8'h22, 8'h2A, 8'h2E, 8'h26, 8'h22};
    logic        clk, srst, sys_n, rq;
    brc_wr_t     wr;
    logic [11:0] rd_addr;
    logic [7:0]  rd_cnt, rd_data, cfg_one, aux_cmd, c1, sp, am;
    logic [7:0]  seen = 8'h00;
    logic        board_rst, sys_ctrl, pon, aux_vld, hold_ok;
    logic [3:0]  clk_div;
    int          err_count = 0, compares = 0, cycles = 0, seed, rv;
    logic [7:0]  exp_q[$], aux_q[$];
    string       name_q[$];

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    brc_reset_ctrl #(.NUM_CH(NCH), .HOLD_CYCLES(HOLD)) dut (
        .i_core_clk(clk), .i_srst(srst), .i_sysreset_n(sys_n), .i_wr(wr),
        .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_board_rst(board_rst),
        .o_sys_ctrl(sys_ctrl), .o_cfg_one(cfg_one), .o_power_on(pon),
        .o_clk_div(clk_div), .o_aux_cmd_vld(aux_vld), .o_aux_cmd(aux_cmd),
        .o_rst_hold_ok(hold_ok));

    brc_host_model #(.HOLD(HOLD), .DEV_VAL(LINE_IRQ), .CHCTL_VAL(CHCTL_IRQ)) host (
        .i_core_clk(clk), .o_wr(wr), .o_rd_addr(rd_addr), .o_rd_cnt(rd_cnt));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] e);
        name_q.push_back(nm);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    // Every channel register either cleared or loaded with the vector
    task automatic dma_init_chk();
        for (int c = 0; c < NCH; c++) begin
            foreach (CH_REGS[i]) begin
                rd("dma_reg", {DMA_PAGE, 2'(c), CH_REGS[i]},
                   (i > 5 && i < 8) ? DMA_VEC_RST : REG_CLR);
            end
        end
        rd("dma_gen", OFS_DMA_GEN, REG_CLR);
    endtask

    task automatic conclude();
        if (exp_q.size() + aux_q.size() != 0) begin
            err_count++;
            $display("[FAIL] pending expected 0 seen %0d", exp_q.size() + aux_q.size());
        end
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Read results land one edge after the address; pulses pop the aux notes
    always @(posedge clk) begin
        rq <= (rd_cnt != seen);
        seen <= rd_cnt;
    end
    always @(negedge clk) begin
        if (rq === 1'b1) begin
            chk(name_q.pop_front(), exp_q.pop_front(), rd_data);
        end
        if (aux_vld === 1'b1) begin
            chk("aux_cmd", (aux_q.size() > 0) ? aux_q.pop_front() : 8'hXX, aux_cmd);
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            $display("[FAIL] cycles expected %0d seen %0d", LIMIT - 1, cycles);
            conclude();
        end
    end

    initial begin
        srst = 1'b1;
        sys_n = 1'b1;
        seed = 70776;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        chk("board_rst", 8'h00, {7'h00, board_rst});
        chk("power_on", 8'h01, {7'h00, pon});
        chk("clk_div", 8'h08, {4'h0, clk_div});
        rd("status", OFS_STATUS, 8'h01);
        rd("unmapped", 12'h7FF, 8'h00);
        dma_init_chk();
        // Aux commands are dropped while power-on is set, others still land
        rv = $random(seed);
        host.wr(OFS_AUX_CMD, {2'b01, rv[5:0]});
        host.wr(OFS_AUX_CMD, AUX_SEND_EOI);
        host.wr(OFS_SPOLL, rv[15:8]);
        rd("status", OFS_STATUS, 8'h01);
        rd("spoll", OFS_SPOLL, rv[15:8]);
        // Full bring-up, then aux decode with power-on cleared
        rv = $random(seed);
        c1 = rv[7:0];
        sp = rv[15:8];
        am = rv[23:16] | 8'h30;
        host.init(c1, rv[31:24], sp, am);
        chk("sys_ctrl", 8'h01, {7'h00, sys_ctrl});
        chk("cfg_one", c1, cfg_one);
        chk("power_on", 8'h00, {7'h00, pon});
        rd("dev1", {DMA_PAGE, 2'b01, DMA_DEV}, LINE_IRQ);
        rd("nvec1", {DMA_PAGE, 2'b01, DMA_NVEC}, rv[31:24]);
        rd("amode", OFS_ADDR_MODE, am);
        foreach (AUX_OP[i]) begin
            host.wr(OFS_AUX_CMD, AUX_OP[i]);
            rd("status", OFS_STATUS, AUX_ST[i]);
        end
        host.wr(OFS_AUX_CMD, AUX_SEND_EOI);
        host.wr(OFS_AUX_CMD, AUX_SET_PPF);
        host.wr(OFS_AUX_CMD, {4'h2, rv[3:0]});
        chk("clk_div", {4'h0, rv[3:0]}, {4'h0, clk_div});
        rv = $random(seed);
        aux_q.push_back({2'b01, rv[5:0]});
        aux_q.push_back({2'b01, rv[13:8]});
        host.wr(OFS_AUX_CMD, {2'b01, rv[5:0]});
        host.wr(OFS_AUX_CMD, {2'b01, rv[13:8]});
        // Local reset: edge-exact rise, writes refused, hold reported
        host.wr(OFS_CFG_TWO, 8'h02);
        chk("board_rst", 8'h00, {7'h00, board_rst});
        @(negedge clk);
        chk("board_rst", 8'h01, {7'h00, board_rst});
        chk("hold_ok", 8'h00, {7'h00, hold_ok});
        host.wr({DMA_PAGE, 2'b00, DMA_DEV}, 8'h55);
        repeat (HOLD + 2) @(negedge clk);
        rd("status", OFS_STATUS, 8'hD1);
        chk("hold_ok", 8'h01, {7'h00, hold_ok});
        host.wr(OFS_CFG_TWO, 8'h00);
        chk("board_rst", 8'h01, {7'h00, board_rst});
        @(negedge clk);
        chk("board_rst", 8'h00, {7'h00, board_rst});
        chk("sys_ctrl", 8'h00, {7'h00, sys_ctrl});
        chk("cfg_one", 8'h00, cfg_one);
        chk("hold_ok", 8'h00, {7'h00, hold_ok});
        chk("power_on", 8'h01, {7'h00, pon});
        chk("clk_div", 8'h08, {4'h0, clk_div});
        rd("status", OFS_STATUS, 8'h01);
        rd("spoll", OFS_SPOLL, 8'h00);
        rd("amode", OFS_ADDR_MODE, am & 8'hCF);
        dma_init_chk();
        // Backplane reset forces the same initialisation and drops the select
        host.wr(OFS_CFG_TWO, 8'h01);
        chk("sys_ctrl", 8'h01, {7'h00, sys_ctrl});
        host.wr(OFS_CFG_ONE, c1);
        sys_n = 1'b0;
        repeat (6) @(negedge clk);
        chk("board_rst", 8'h01, {7'h00, board_rst});
        chk("sys_ctrl", 8'h00, {7'h00, sys_ctrl});
        chk("cfg_one", 8'h00, cfg_one);
        sys_n = 1'b1;
        repeat (6) @(negedge clk);
        chk("board_rst", 8'h00, {7'h00, board_rst});
        rd("status", OFS_STATUS, 8'h01);
        dma_init_chk();
        repeat (3) @(negedge clk);
        conclude();
    end
endmodule // board_reset_and_init_control_test

// File: brc_host_model.sv
// Host processor model on the backplane: byte writes and read addresses.
// Assumes the bench calls its tasks in step with the falling clock edge.
`timescale 1ns/1ps
module brc_host_model
    import brc_pkg::*;
#(
    parameter int unsigned HOLD    = 16,
    parameter logic [7:0]  DEV_VAL   = 8'h01,
    parameter logic [7:0]  CHCTL_VAL = 8'h08
) (
    input  wire logic   i_core_clk,
    output brc_wr_t     o_wr,
    output logic [11:0] o_rd_addr,
    output logic [7:0]  o_rd_cnt
);
    // Idle port at time zero, read address parked on an unmapped place
    initial begin
        o_wr = '0;
        o_rd_addr = 12'h7FF;
        o_rd_cnt = 8'h00;
    end

    // One write; the idle edge before it keeps strobes from colliding
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_wr = '{en: 1'b1, addr: a, data: d};
        @(negedge i_core_clk);
        o_wr.en = 1'b0;
    endtask

    // One read; the counter step tells the watcher a result is due
    task automatic rd(input logic [11:0] a);
        @(negedge i_core_clk);
        o_rd_addr = a;
        o_rd_cnt = o_rd_cnt + 8'h01;
    endtask

    // Bring-up order; every chip register of interest is reloaded
    task automatic init(input logic [7:0] c1, input logic [7:0] sid,
                        input logic [7:0] sp, input logic [7:0] am);
        wr(OFS_CFG_TWO, 8'h02);
        repeat (HOLD) @(negedge i_core_clk);
        wr(OFS_CFG_TWO, 8'h00);
        wr(OFS_CFG_ONE, c1);
        wr(OFS_CFG_TWO, 8'h01);
        wr({DMA_PAGE, 2'b01, DMA_DEV}, DEV_VAL);
        wr({DMA_PAGE, 2'b01, DMA_CHCTL}, CHCTL_VAL);
        wr({DMA_PAGE, 2'b01, DMA_NVEC}, sid);
        wr({DMA_PAGE, 2'b01, DMA_EVEC}, sid);
        wr(OFS_ADDR_MODE, am);
        wr(OFS_SPOLL, sp);
        wr(OFS_AUX_CMD, AUX_IEPON);
    endtask
endmodule // brc_host_model

// File: brc_pin_sync.sv
// Three-stage synchroniser with agreement filter for one board pin.
// Assumes the pin is asynchronous to i_core_clk.
`timescale 1ns/1ps
module brc_pin_sync #(
    parameter logic RST_LEVEL = 1'b1
) (
    input  wire logic i_core_clk,
    input  wire logic i_srst,
    input  wire logic i_pin,
    output logic      o_level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } brc_sync_st_t;

    brc_sync_st_t s_r;
    brc_sync_st_t s_nxt;

    // First stage only feeds the second; level moves when stages two and three agree
    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = i_pin;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        if (s_r.s2 == s_r.s3) begin
            s_nxt.lvl = s_r.s3;
        end
    end

    // Reset parks all stages at the idle pin level
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s_r <= {RST_LEVEL, RST_LEVEL, RST_LEVEL, RST_LEVEL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_level = s_r.lvl;

endmodule // brc_pin_sync

// File: brc_pkg.sv
// Shared constants and carrier types for the board reset and init control.
// Assumes one 100 MHz core clock and a byte-wide register write port.
package brc_pkg;

    // Clock and hold time
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned RST_HOLD_MS   = 10;
    localparam int unsigned RST_HOLD_CYC  = (CLK_HZ / 1000) * RST_HOLD_MS;

    // Board configuration registers
    localparam logic [11:0] OFS_CFG_ONE   = 12'h101;
    localparam logic [11:0] OFS_CFG_TWO   = 12'h105;
    localparam int unsigned CFG_TWO_SEL_BIT = 0;
    localparam int unsigned CFG_TWO_RST_BIT = 1;

    // Interface chip registers
    localparam logic [11:0] OFS_SPOLL     = 12'h003;
    localparam logic [11:0] OFS_ADDR_MODE = 12'h004;
    localparam logic [11:0] OFS_AUX_CMD   = 12'h005;
    localparam logic [11:0] OFS_STATUS    = 12'h00F;
    localparam int unsigned AMODE_TR0_BIT = 4;
    localparam int unsigned AMODE_TR1_BIT = 5;
    localparam logic [3:0]  CLK_DIV_RST   = 4'h8;

    // Auxiliary command codes
    localparam logic [7:0]  AUX_IEPON     = 8'h00;
    localparam logic [7:0]  AUX_CLR_PPF   = 8'h01;
    localparam logic [7:0]  AUX_SEND_EOI  = 8'h06;
    localparam logic [7:0]  AUX_SET_PPF   = 8'h09;
    localparam logic [7:0]  AUX_CLR_REQSYS = 8'h16;
    localparam logic [7:0]  AUX_SET_REQSYS = 8'h1E;
    localparam logic [2:0]  AUX_GRP_IMM   = 3'h0;
    localparam logic [2:0]  AUX_GRP_DIV   = 3'h1;
    localparam logic [2:0]  AUX_GRP_A     = 3'h4;
    localparam logic [2:0]  AUX_GRP_B     = 3'h5;
    localparam logic [2:0]  AUX_GRP_E     = 3'h6;

    // DMA controller map: page, channel stride 0x40, register within
    localparam logic [3:0]  DMA_PAGE      = 4'h2;
    localparam logic [11:0] OFS_DMA_GEN   = 12'h2FF;
    localparam logic [5:0]  DMA_STAT      = 6'h00;
    localparam logic [5:0]  DMA_ERR       = 6'h01;
    localparam logic [5:0]  DMA_DEV       = 6'h04;
    localparam logic [5:0]  DMA_OPER      = 6'h05;
    localparam logic [5:0]  DMA_SEQ       = 6'h06;
    localparam logic [5:0]  DMA_CHCTL     = 6'h07;
    localparam logic [5:0]  DMA_NVEC      = 6'h25;
    localparam logic [5:0]  DMA_EVEC      = 6'h27;
    localparam logic [5:0]  DMA_PRIO      = 6'h2D;
    localparam logic [7:0]  DMA_VEC_RST   = 8'h0F;
    localparam logic [7:0]  REG_CLR       = 8'h00;

    typedef struct packed {
        logic        en;
        logic [11:0] addr;
        logic [7:0]  data;
    } brc_wr_t;

    typedef struct packed {
        logic       pon;
        logic [7:0] spoll;
        logic       eoi;
        logic [4:0] aux_a;
        logic [4:0] aux_b;
        logic [4:0] aux_e;
        logic       ppf;
        logic       req_sys;
        logic [3:0] clk_div;
        logic [7:0] amode;
    } brc_chip_t;

    typedef struct packed {
        logic [7:0] dev;
        logic [7:0] oper;
        logic [7:0] seq;
        logic [7:0] chctl;
        logic [7:0] stat;
        logic [7:0] prio;
        logic [7:0] err;
        logic [7:0] nvec;
        logic [7:0] evec;
    } brc_dma_ch_t;

endpackage

// File: brc_reset_ctrl.sv
// Board reset generation and reset-time initialisation of the interface
// chip and DMA controller state. Assumes a byte write port and a pin-level
// backplane system reset (active low) from outside the clock domain.
`timescale 1ns/1ps
// Summary of operation
// R1: Local reset bit drives board reset line
// R2: Host holds local reset bit ten ms
// R3: Backplane system reset forces local reset
// R4: Config bit 0 selects system controller
// R5: System controller bit clears on reset
// R6: Board reset clears configs, initialises all blocks
// R7: Local reset bit equals full system reset
// R8: Reset sets power-on, interface functions idle
// R9: Reset clears poll, EOI, aux, flags
// R10: Reset loads clock divider with eight
// R11: Reset clears both transit receive bits
// R12: Aux commands discarded while power-on set
// R13: Immediate power-on command clears power-on
// R14: Host treats uninitialised chip registers undefined
// R15: Reset clears all DMA channel registers
// R16: Reset loads DMA vectors with 0x0F
// R17: Host pulses reset, loads configs, masks
// R18: Host sets peripheral lines and enable
// R19: Host writes status byte to vectors
// R20: Host loads addresses, modes, poll responses
// R21: Host clears power-on last, then commands
// R22: Reset release aligned to core clock
module brc_reset_ctrl
    import brc_pkg::*;
#(
    parameter int unsigned NUM_CH      = 4,
    parameter int unsigned HOLD_CYCLES = RST_HOLD_CYC
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_srst,
    input  wire logic       i_sysreset_n,
    input  wire brc_wr_t    i_wr,
    input  wire logic [11:0] i_rd_addr,
    output logic [7:0]      o_rd_data,
    output logic            o_board_rst,
    output logic            o_sys_ctrl,
    output logic [7:0]      o_cfg_one,
    output logic            o_power_on,
    output logic [3:0]      o_clk_div,
    output logic            o_aux_cmd_vld,
    output logic [7:0]      o_aux_cmd,
    output logic            o_rst_hold_ok
);
    typedef struct packed {
        logic                     rst;
        logic                     lrst;
        logic                     sys_sel;
        logic [7:0]               cfg_one;
        logic [19:0]              hold_cnt;
        logic                     hold_ok;
        brc_chip_t                chip;
        logic [7:0]               gen_ctl;
        brc_dma_ch_t [NUM_CH-1:0] ch;
        logic [7:0]               rd_data;
        logic                     aux_vld;
        logic [7:0]               aux_cmd;
    } brc_st_t;

    localparam logic [19:0] HOLD_LIM = 20'(HOLD_CYCLES);

    brc_st_t s_r;
    brc_st_t s_nxt;
    logic    pin_level;
    logic    sys_act;

    // Address lands in the DMA page on an existing channel
    function automatic logic is_dma(input logic [11:0] a);
        return (a[11:8] == DMA_PAGE) && (int'(a[7:6]) < NUM_CH);
    endfunction

    function automatic logic [7:0] dma_rd(input brc_dma_ch_t c, input logic [5:0] r);
        logic [7:0] v;
        v = REG_CLR;
        unique case (r)
            DMA_STAT:  v = c.stat;
            DMA_ERR:   v = c.err;
            DMA_DEV:   v = c.dev;
            DMA_OPER:  v = c.oper;
            DMA_SEQ:   v = c.seq;
            DMA_CHCTL: v = c.chctl;
            DMA_NVEC:  v = c.nvec;
            DMA_EVEC:  v = c.evec;
            DMA_PRIO:  v = c.prio;
            default:   v = REG_CLR;
        endcase
        return v;
    endfunction

    function automatic brc_dma_ch_t dma_wr(input brc_dma_ch_t c, input logic [5:0] r,
                                           input logic [7:0] d);
        brc_dma_ch_t n;
        n = c;
        unique case (r)
            DMA_STAT:  n.stat  = d;
            DMA_ERR:   n.err   = d;
            DMA_DEV:   n.dev   = d;
            DMA_OPER:  n.oper  = d;
            DMA_SEQ:   n.seq   = d;
            DMA_CHCTL: n.chctl = d;
            DMA_NVEC:  n.nvec  = d;
            DMA_EVEC:  n.evec  = d;
            DMA_PRIO:  n.prio  = d;
            default:   n       = c;
        endcase
        return n;
    endfunction

    // Backplane reset pin, filtered into the core domain
    brc_pin_sync #(
        .RST_LEVEL (1'b1)
    ) u_sysreset_sync (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_pin      (i_sysreset_n),
        .o_level    (pin_level)
    );

    assign sys_act = ~pin_level;

    // Next-state logic: writes first, reset initialisation last so it wins
    always_comb begin
        s_nxt         = s_r;
        s_nxt.aux_vld = 1'b0;

        // Board reset is one registered level, so every block leaves it together
        s_nxt.rst = sys_act | s_r.lrst; // R1 R3 R7 R22

        // Configuration two stays writable during reset so the host can release it
        if (i_wr.en && (i_wr.addr == OFS_CFG_TWO)) begin
            s_nxt.lrst    = i_wr.data[CFG_TWO_RST_BIT]; // R1
            s_nxt.sys_sel = i_wr.data[CFG_TWO_SEL_BIT]; // R4
        end
        if (i_wr.en && (i_wr.addr == OFS_CFG_ONE)) begin
            s_nxt.cfg_one = i_wr.data;
        end

        // Hold timer: lets software see the local reset has lasted long enough
        if (!s_r.lrst) begin
            s_nxt.hold_cnt = '0;
            s_nxt.hold_ok  = 1'b0;
        end else if (s_r.hold_cnt != HOLD_LIM) begin
            s_nxt.hold_cnt = s_r.hold_cnt + 20'h00001;
        end else begin
            s_nxt.hold_ok = 1'b1;
        end

        // Chip and DMA writes; ignored while the board is held in reset
        if (i_wr.en && !s_r.rst) begin
            if (i_wr.addr == OFS_SPOLL) begin
                s_nxt.chip.spoll = i_wr.data;
            end
            if (i_wr.addr == OFS_ADDR_MODE) begin
                s_nxt.chip.amode = i_wr.data;
            end
            if (i_wr.addr == OFS_DMA_GEN) begin
                s_nxt.gen_ctl = i_wr.data;
            end
            if (is_dma(i_wr.addr)) begin
                s_nxt.ch[i_wr.addr[7:6]] = dma_wr(s_r.ch[i_wr.addr[7:6]],
                                                  i_wr.addr[5:0], i_wr.data);
            end
            // Only the immediate power-on command gets past a set power-on
            if (i_wr.addr == OFS_AUX_CMD) begin
                if (i_wr.data == AUX_IEPON) begin
                    s_nxt.chip.pon = 1'b0; // R13
                end else if (!s_r.chip.pon) begin // R12
                    unique case (i_wr.data[7:5])
                        AUX_GRP_DIV: s_nxt.chip.clk_div = i_wr.data[3:0];
                        AUX_GRP_A:   s_nxt.chip.aux_a   = i_wr.data[4:0];
                        AUX_GRP_B:   s_nxt.chip.aux_b   = i_wr.data[4:0];
                        AUX_GRP_E:   s_nxt.chip.aux_e   = i_wr.data[4:0];
                        AUX_GRP_IMM: begin
                            unique case (i_wr.data)
                                AUX_SEND_EOI: s_nxt.chip.eoi = 1'b1;
                                AUX_SET_REQSYS: s_nxt.chip.req_sys = 1'b1;
                                AUX_CLR_REQSYS: s_nxt.chip.req_sys = 1'b0;
                                AUX_SET_PPF:  s_nxt.chip.ppf = 1'b1;
                                AUX_CLR_PPF:  s_nxt.chip.ppf = 1'b0;
                                default: begin
                                    s_nxt.aux_vld = 1'b1;
                                    s_nxt.aux_cmd = i_wr.data;
                                end
                            endcase
                        end
                        default: begin
                            s_nxt.aux_vld = 1'b1;
                            s_nxt.aux_cmd = i_wr.data;
                        end
                    endcase
                end
            end
        end

        // Initialisation while board reset is asserted
        if (s_r.rst) begin
            s_nxt.sys_sel = 1'b0;    // R5 R6
            s_nxt.cfg_one = REG_CLR; // R6
            // Backplane reset clears the local bit too; local reset keeps it held
            if (sys_act) begin
                s_nxt.lrst = 1'b0; // R6
            end
            s_nxt.chip.pon     = 1'b1;    // R8
            s_nxt.chip.spoll   = REG_CLR; // R9
            s_nxt.chip.eoi     = 1'b0;    // R9
            s_nxt.chip.aux_a   = '0;      // R9
            s_nxt.chip.aux_b   = '0;      // R9
            s_nxt.chip.aux_e   = '0;      // R9
            s_nxt.chip.ppf     = 1'b0;    // R9
            s_nxt.chip.req_sys = 1'b0;    // R9
            s_nxt.chip.clk_div = CLK_DIV_RST; // R10
            // Other mode bits are left as they were, software must reload them
            s_nxt.chip.amode[AMODE_TR0_BIT] = 1'b0; // R11
            s_nxt.chip.amode[AMODE_TR1_BIT] = 1'b0; // R11
            s_nxt.gen_ctl = REG_CLR; // R15
            for (int i = 0; i < NUM_CH; i++) begin
                s_nxt.ch[i].dev   = REG_CLR;     // R15
                s_nxt.ch[i].oper  = REG_CLR;
                s_nxt.ch[i].seq   = REG_CLR;
                s_nxt.ch[i].chctl = REG_CLR;
                s_nxt.ch[i].stat  = REG_CLR;
                s_nxt.ch[i].prio  = REG_CLR;
                s_nxt.ch[i].err   = REG_CLR;
                s_nxt.ch[i].nvec  = DMA_VEC_RST; // R16
                s_nxt.ch[i].evec  = DMA_VEC_RST; // R16
            end
            s_nxt.aux_vld = 1'b0;
        end

        // Registered read port, one cycle latency; unmapped reads give zero
        s_nxt.rd_data = REG_CLR;
        if (i_rd_addr == OFS_SPOLL) begin
            s_nxt.rd_data = s_r.chip.spoll;
        end else if (i_rd_addr == OFS_ADDR_MODE) begin
            s_nxt.rd_data = s_r.chip.amode;
        end else if (i_rd_addr == OFS_STATUS) begin
            s_nxt.rd_data = {s_r.rst, s_r.hold_ok, s_r.sys_sel, s_r.lrst,
                             s_r.chip.req_sys, s_r.chip.ppf, s_r.chip.eoi, s_r.chip.pon};
        end else if (i_rd_addr == OFS_DMA_GEN) begin
            s_nxt.rd_data = s_r.gen_ctl;
        end else if (is_dma(i_rd_addr)) begin
            s_nxt.rd_data = dma_rd(s_r.ch[i_rd_addr[7:6]], i_rd_addr[5:0]);
        end
    end

    // Core reset holds the board in reset; the next edge runs full initialisation
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s_r              <= '0;
            s_r.rst          <= 1'b1;
            s_r.chip.pon     <= 1'b1;
            s_r.chip.clk_div <= CLK_DIV_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rd_data     = s_r.rd_data;
    assign o_board_rst   = s_r.rst;
    assign o_sys_ctrl    = s_r.sys_sel;
    assign o_cfg_one     = s_r.cfg_one;
    assign o_power_on    = s_r.chip.pon;
    assign o_clk_div     = s_r.chip.clk_div;
    assign o_aux_cmd_vld = s_r.aux_vld;
    assign o_aux_cmd     = s_r.aux_cmd;
    assign o_rst_hold_ok = s_r.hold_ok;

    // Helper for checks: every DMA channel at its reset contents
    logic dma_at_init;
    always_comb begin
        dma_at_init = (s_r.gen_ctl == REG_CLR);
        for (int i = 0; i < NUM_CH; i++) begin
            if ({s_r.ch[i].dev, s_r.ch[i].oper, s_r.ch[i].seq, s_r.ch[i].chctl,
                 s_r.ch[i].stat, s_r.ch[i].prio, s_r.ch[i].err} != '0 ||
                s_r.ch[i].nvec != DMA_VEC_RST || s_r.ch[i].evec != DMA_VEC_RST) begin
                dma_at_init = 1'b0;
            end
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    sequence seq_lrst_rise;
        !s_r.lrst ##1 s_r.lrst;
    endsequence

    sequence seq_rst_init;
        s_r.rst ##1 (s_r.chip.pon && o_clk_div == CLK_DIV_RST);
    endsequence

    a_lrst_drives_rst: assert property (s_r.lrst |=> o_board_rst) // R1
        else $error("local reset bit did not drive board reset");
    a_rst_release: assert property (!s_r.lrst && !sys_act |=> !o_board_rst) // R22
        else $error("board reset not released on the next edge");
    a_sysreset_forces: assert property (sys_act |=> o_board_rst ##1 !s_r.lrst) // R3
        else $error("backplane reset did not force board reset");
    a_sel_select: assert property (i_wr.en && i_wr.addr == OFS_CFG_TWO && !s_r.rst
                                   |=> o_sys_ctrl == $past(i_wr.data[CFG_TWO_SEL_BIT])) // R4
        else $error("system controller bit not taken from write");
    a_rst_clears_cfg: assert property (o_board_rst |=> !o_sys_ctrl && o_cfg_one == REG_CLR) // R5
        else $error("configuration not cleared by reset");
    a_lrst_full_init: assert property (seq_lrst_rise |-> ##1 seq_rst_init) // R7
        else $error("local reset did not run full initialisation");
    a_chip_init: assert property (o_board_rst |=> s_r.chip.pon && s_r.chip.spoll == REG_CLR
                                  && !s_r.chip.eoi && s_r.chip.aux_a == '0
                                  && s_r.chip.aux_b == '0 && s_r.chip.aux_e == '0
                                  && !s_r.chip.ppf && !s_r.chip.req_sys) // R8 R9
        else $error("interface chip not initialised by reset");
    a_div_tr_init: assert property (o_board_rst |=> o_clk_div == CLK_DIV_RST
                                    && !s_r.chip.amode[AMODE_TR0_BIT]
                                    && !s_r.chip.amode[AMODE_TR1_BIT]) // R10 R11
        else $error("divider or transit bits wrong after reset");
    a_aux_discard: assert property (o_power_on && !o_board_rst && i_wr.en
                                    && i_wr.addr == OFS_AUX_CMD && i_wr.data != AUX_IEPON
                                    |=> !o_aux_cmd_vld && $stable(o_clk_div)) // R12
        else $error("aux command executed while power-on set");
    a_iepon_clears: assert property (!o_board_rst && i_wr.en && i_wr.addr == OFS_AUX_CMD
                                     && i_wr.data == AUX_IEPON |=> !o_power_on) // R13
        else $error("immediate power-on command did not clear power-on");
    a_dma_init: assert property (o_board_rst |=> dma_at_init) // R15 R16
        else $error("DMA registers not at reset values");

endmodule // brc_reset_ctrl
